// >>> uart_fc_pkg.sv
// constants and state types of the flow controlled multidrop uart
// assumes one clock; configuration inputs stay stable during a frame
// Functional notes
// - every frame opens with a low start bit, then the data bits
// - optional parity bit makes data plus parity even or odd
// - stop bits are high and the idle line rests high
// - receiver restarts bit timing at each falling edge into a start bit
// - stop period is set from one to three bit periods
// - standard data field width is five to eight bits
// - rts active while receive fifo holds fewer entries than the level
// - rts stays inactive until reads bring occupancy below the level
// - transmitter checks cts before each character and waits while inactive
// - rts and cts are active low unless their polarity is inverted
// - rts and cts handling are enabled separately
// - multiprocessor characters carry nine bits, top bit flags an address
// - multiprocessor frame has nine data bits and no parity
// - slave compares received addresses with address under mask
// - matching address is stored only when accepting addresses is set
// - data after match is stored, after mismatch dropped until next address
// - both master and slave multiprocessor roles are supported

package uart_fc_pkg;
	localparam int DATA_W = 9;
	localparam int FIFO_DEPTH = 8;
	localparam int DIV_W = 16;
	localparam int ADDR_FLAG = 8;
	localparam logic [3:0] LEN_BASE = 4'h5;
	localparam logic [3:0] LEN_MP = 4'h9;
	localparam logic [3:0] LEN_ONE = 4'h1;
	localparam logic [1:0] STOP_MIN = 2'h1;
	localparam logic [8:0] ALL_ONES = 9'h1ff;
	localparam logic LINE_IDLE = 1'b1;
	localparam logic LINE_START = 1'b0;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_START = 3'h1,
		TX_DATA = 3'h3,
		TX_PAR = 3'h2,
		TX_STOP = 3'h6
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h3,
		RX_PAR = 3'h2,
		RX_STOP = 3'h6
	} rx_state_t;
endpackage

// >>> uart_flow_control_multidrop.sv
// uart transmitter and receiver with rts/cts and 9-bit multidrop filter
// assumes inputs synchronous to clock_i and config stable within a frame
`timescale 1ns/1ps

module uart_flow_control_multidrop #(
	parameter int DEPTH = uart_fc_pkg::FIFO_DEPTH,
	parameter int DIV_W = uart_fc_pkg::DIV_W,
	localparam int CNT_W = $clog2(DEPTH + 1),
	localparam int PTR_W = $clog2(DEPTH)
) (
	input wire logic clock_i, // 50 MHz
	input wire logic reset_n_i, // async, active low
	input wire logic [DIV_W-1:0] bit_div_i, // clocks per bit, >= 2
	input wire logic [1:0] data_len_i, // 0..3 = 5..8 bits
	input wire logic parity_en_i, // parity bit on
	input wire logic parity_odd_i, // 1 odd, 0 even
	input wire logic [1:0] stop_bits_i, // 1..3, 0 as 1
	input wire logic mp_mode_i, // 9-bit multiprocessor
	input wire logic mp_slave_i, // slave filtering on
	input wire logic [7:0] mp_addr_i, // own address
	input wire logic [7:0] mp_mask_i, // compared bits
	input wire logic mp_accept_i, // store matching address
	input wire logic rts_en_i, // rts handling on
	input wire logic rts_pol_i, // 0 active low
	input wire logic [CNT_W-1:0] rts_level_i, // rx fifo level
	input wire logic cts_en_i, // cts handling on
	input wire logic cts_pol_i, // 0 active low
	input wire logic tx_valid_i, // write tx word
	input wire logic [8:0] tx_data_i, // tx word
	output logic tx_ready_o, // tx fifo not full
	input wire logic rx_read_i, // pop rx fifo
	output logic [8:0] rx_data_o, // popped word
	output logic rx_data_valid_o, // pop result pulse
	output logic [CNT_W-1:0] rx_count_o, // rx fifo entries
	output logic parity_err_o, // sticky parity error
	output logic frame_err_o, // sticky stop error
	input wire logic err_clr_i, // clears error flags
	input wire logic rx_i, // serial in
	output logic tx_o, // serial out
	input wire logic cts_i, // clear to send pin
	output logic rts_o // request to send pin
);
	function automatic logic [3:0] frame_len(input logic mp,
			input logic [1:0] len);
		return mp ? uart_fc_pkg::LEN_MP :
			uart_fc_pkg::LEN_BASE + {2'h0, len};
	endfunction

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	logic [3:0] len;
	logic par_on;
	logic [DIV_W-1:0] reload;
	logic cts_ok;
	assign len = frame_len(mp_mode_i, data_len_i);
	assign par_on = parity_en_i && !mp_mode_i;
	assign reload = bit_div_i - 1'b1;
	assign cts_ok = !cts_en_i || (cts_i == cts_pol_i);

	// tx fifo
	logic [8:0] tx_mem_reg [DEPTH];
	logic [8:0] tx_mem_next [DEPTH];
	logic [PTR_W-1:0] tx_wp_reg, tx_wp_next, tx_rp_reg, tx_rp_next;
	logic [CNT_W-1:0] tx_cnt_reg, tx_cnt_next;
	logic tx_ready_next, tx_push, tx_pop;

	always_comb begin
		tx_mem_next = tx_mem_reg;
		tx_wp_next = tx_wp_reg;
		tx_rp_next = tx_rp_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_push = tx_valid_i && tx_ready_o;
		if (tx_push) begin
			tx_mem_next[tx_wp_reg] = tx_data_i;
			tx_wp_next = ptr_inc(tx_wp_reg);
		end
		if (tx_pop) begin
			tx_rp_next = ptr_inc(tx_rp_reg);
		end
		if (tx_push && !tx_pop) begin
			tx_cnt_next = tx_cnt_reg + 1'b1;
		end else if (tx_pop && !tx_push) begin
			tx_cnt_next = tx_cnt_reg - 1'b1;
		end
		tx_ready_next = tx_cnt_next != CNT_W'(DEPTH);
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				tx_mem_reg[i] <= '0;
			end
			tx_wp_reg <= '0;
			tx_rp_reg <= '0;
			tx_cnt_reg <= '0;
			tx_ready_o <= 1'b1;
		end else begin
			tx_mem_reg <= tx_mem_next;
			tx_wp_reg <= tx_wp_next;
			tx_rp_reg <= tx_rp_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_ready_o <= tx_ready_next;
		end
	end

	// tx engine
	uart_fc_pkg::tx_state_t tx_state_reg, tx_state_next;
	logic [DIV_W-1:0] tx_div_reg, tx_div_next;
	logic [3:0] tx_bit_reg, tx_bit_next;
	logic [8:0] tx_shift_reg, tx_shift_next, tx_word_reg, tx_word_next;
	logic [1:0] tx_stop_reg, tx_stop_next;
	logic tx_line_next, tx_par;

	assign tx_par = ^(tx_word_reg & (uart_fc_pkg::ALL_ONES >>
		(uart_fc_pkg::LEN_MP - len))) ^ parity_odd_i;

	always_comb begin
		tx_state_next = tx_state_reg;
		tx_div_next = tx_div_reg;
		tx_bit_next = tx_bit_reg;
		tx_shift_next = tx_shift_reg;
		tx_word_next = tx_word_reg;
		tx_stop_next = tx_stop_reg;
		tx_line_next = tx_o;
		tx_pop = 1'b0;
		if (tx_state_reg != uart_fc_pkg::TX_IDLE) begin
			tx_div_next = (tx_div_reg == '0) ? reload : tx_div_reg - 1'b1;
		end
		case (tx_state_reg)
			uart_fc_pkg::TX_IDLE: begin
				tx_line_next = uart_fc_pkg::LINE_IDLE;
				if (tx_cnt_reg != '0 && cts_ok) begin
					tx_pop = 1'b1;
					tx_word_next = tx_mem_reg[tx_rp_reg];
					tx_shift_next = tx_mem_reg[tx_rp_reg];
					tx_div_next = reload;
					tx_state_next = uart_fc_pkg::TX_START;
					tx_line_next = uart_fc_pkg::LINE_START;
				end
			end
			uart_fc_pkg::TX_START: begin
				if (tx_div_reg == '0) begin
					tx_bit_next = '0;
					tx_line_next = tx_shift_reg[0];
					tx_state_next = uart_fc_pkg::TX_DATA;
				end
			end
			uart_fc_pkg::TX_DATA: begin
				if (tx_div_reg == '0) begin
					tx_shift_next = tx_shift_reg >> 1;
					tx_bit_next = tx_bit_reg + 1'b1;
					tx_line_next = tx_shift_reg[1];
					if (tx_bit_reg == len - uart_fc_pkg::LEN_ONE) begin
						tx_stop_next = (stop_bits_i == '0) ? '0 :
							stop_bits_i - uart_fc_pkg::STOP_MIN;
						if (par_on) begin
							tx_line_next = tx_par;
							tx_state_next = uart_fc_pkg::TX_PAR;
						end else begin
							tx_line_next = uart_fc_pkg::LINE_IDLE;
							tx_state_next = uart_fc_pkg::TX_STOP;
						end
					end
				end
			end
			uart_fc_pkg::TX_PAR: begin
				if (tx_div_reg == '0) begin
					tx_line_next = uart_fc_pkg::LINE_IDLE;
					tx_state_next = uart_fc_pkg::TX_STOP;
				end
			end
			uart_fc_pkg::TX_STOP: begin
				tx_line_next = uart_fc_pkg::LINE_IDLE;
				if (tx_div_reg == '0) begin
					if (tx_stop_reg == '0) begin
						tx_state_next = uart_fc_pkg::TX_IDLE;
					end else begin
						tx_stop_next = tx_stop_reg - 1'b1;
					end
				end
			end
			default: begin
				tx_state_next = uart_fc_pkg::TX_IDLE;
				tx_line_next = uart_fc_pkg::LINE_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_state_reg <= uart_fc_pkg::TX_IDLE;
			tx_div_reg <= '0;
			tx_bit_reg <= '0;
			tx_shift_reg <= '0;
			tx_word_reg <= '0;
			tx_stop_reg <= '0;
			tx_o <= uart_fc_pkg::LINE_IDLE;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_div_reg <= tx_div_next;
			tx_bit_reg <= tx_bit_next;
			tx_shift_reg <= tx_shift_next;
			tx_word_reg <= tx_word_next;
			tx_stop_reg <= tx_stop_next;
			tx_o <= tx_line_next;
		end
	end

	// rx engine
	uart_fc_pkg::rx_state_t rx_state_reg, rx_state_next;
	logic [DIV_W-1:0] rx_div_reg, rx_div_next;
	logic [3:0] rx_bit_reg, rx_bit_next;
	logic [8:0] rx_shift_reg, rx_shift_next, rx_word;
	logic rx_prev_reg, rx_match_reg, rx_match_next;
	logic rx_done, rx_store, rx_push, rx_hit, perr_set, ferr_set;

	assign rx_word = rx_shift_reg >> (uart_fc_pkg::LEN_MP - len);
	assign rx_hit = ((rx_word[7:0] ^ mp_addr_i) & mp_mask_i) == '0;

	always_comb begin
		rx_state_next = rx_state_reg;
		rx_div_next = (rx_div_reg == '0) ? reload : rx_div_reg - 1'b1;
		rx_bit_next = rx_bit_reg;
		rx_shift_next = rx_shift_reg;
		rx_match_next = rx_match_reg;
		rx_done = 1'b0;
		rx_store = 1'b0;
		perr_set = 1'b0;
		ferr_set = 1'b0;
		case (rx_state_reg)
			uart_fc_pkg::RX_IDLE: begin
				if (rx_prev_reg && !rx_i) begin
					rx_div_next = bit_div_i >> 1;
					rx_state_next = uart_fc_pkg::RX_START;
				end
			end
			uart_fc_pkg::RX_START: begin
				if (rx_div_reg == '0) begin
					rx_bit_next = '0;
					rx_state_next = rx_i ? uart_fc_pkg::RX_IDLE :
						uart_fc_pkg::RX_DATA;
				end
			end
			uart_fc_pkg::RX_DATA: begin
				if (rx_div_reg == '0) begin
					rx_shift_next = {rx_i, rx_shift_reg[8:1]};
					rx_bit_next = rx_bit_reg + 1'b1;
					if (rx_bit_reg == len - uart_fc_pkg::LEN_ONE) begin
						rx_state_next = par_on ? uart_fc_pkg::RX_PAR :
							uart_fc_pkg::RX_STOP;
					end
				end
			end
			uart_fc_pkg::RX_PAR: begin
				if (rx_div_reg == '0) begin
					perr_set = ^rx_word ^ rx_i ^ parity_odd_i;
					rx_state_next = uart_fc_pkg::RX_STOP;
				end
			end
			uart_fc_pkg::RX_STOP: begin
				if (rx_div_reg == '0) begin
					ferr_set = !rx_i;
					rx_done = 1'b1;
					rx_state_next = uart_fc_pkg::RX_IDLE;
				end
			end
			default: begin
				rx_state_next = uart_fc_pkg::RX_IDLE;
			end
		endcase
		if (rx_done && !(mp_mode_i && mp_slave_i)) begin
			rx_store = 1'b1;
		end else if (rx_done && rx_word[uart_fc_pkg::ADDR_FLAG]) begin
			rx_match_next = rx_hit;
			rx_store = rx_hit && mp_accept_i;
		end else if (rx_done) begin
			rx_store = rx_match_reg;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_state_reg <= uart_fc_pkg::RX_IDLE;
			rx_div_reg <= '0;
			rx_bit_reg <= '0;
			rx_shift_reg <= '0;
			rx_prev_reg <= uart_fc_pkg::LINE_IDLE;
			rx_match_reg <= 1'b0;
		end else begin
			rx_state_reg <= rx_state_next;
			rx_div_reg <= rx_div_next;
			rx_bit_reg <= rx_bit_next;
			rx_shift_reg <= rx_shift_next;
			rx_prev_reg <= rx_i;
			rx_match_reg <= rx_match_next;
		end
	end

	// rx fifo, flags, rts
	logic [8:0] rx_mem_reg [DEPTH];
	logic [8:0] rx_mem_next [DEPTH];
	logic [PTR_W-1:0] rx_wp_reg, rx_wp_next, rx_rp_reg, rx_rp_next;
	logic [CNT_W-1:0] rx_cnt_next;
	logic [8:0] rx_data_next;
	logic rx_pop, perr_next, ferr_next, rts_next;

	always_comb begin
		rx_mem_next = rx_mem_reg;
		rx_wp_next = rx_wp_reg;
		rx_rp_next = rx_rp_reg;
		rx_cnt_next = rx_count_o;
		rx_data_next = rx_data_o;
		rx_push = rx_store && rx_count_o != CNT_W'(DEPTH);
		rx_pop = rx_read_i && rx_count_o != '0;
		if (rx_push) begin
			rx_mem_next[rx_wp_reg] = rx_word;
			rx_wp_next = ptr_inc(rx_wp_reg);
		end
		if (rx_pop) begin
			rx_data_next = rx_mem_reg[rx_rp_reg];
			rx_rp_next = ptr_inc(rx_rp_reg);
		end
		if (rx_push && !rx_pop) begin
			rx_cnt_next = rx_count_o + 1'b1;
		end else if (rx_pop && !rx_push) begin
			rx_cnt_next = rx_count_o - 1'b1;
		end
		// set wins over clear
		perr_next = perr_set || (parity_err_o && !err_clr_i);
		ferr_next = ferr_set || (frame_err_o && !err_clr_i);
		rts_next = (!rts_en_i || rx_count_o < rts_level_i) ? rts_pol_i :
			!rts_pol_i;
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				rx_mem_reg[i] <= '0;
			end
			rx_wp_reg <= '0;
			rx_rp_reg <= '0;
			rx_count_o <= '0;
			rx_data_o <= '0;
			rx_data_valid_o <= 1'b0;
			parity_err_o <= 1'b0;
			frame_err_o <= 1'b0;
			rts_o <= 1'b0;
		end else begin
			rx_mem_reg <= rx_mem_next;
			rx_wp_reg <= rx_wp_next;
			rx_rp_reg <= rx_rp_next;
			rx_count_o <= rx_cnt_next;
			rx_data_o <= rx_data_next;
			rx_data_valid_o <= rx_pop;
			parity_err_o <= perr_next;
			frame_err_o <= ferr_next;
			rts_o <= rts_next;
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence seq_tx_go;
		tx_state_reg == uart_fc_pkg::TX_IDLE && tx_cnt_reg != '0 && cts_ok;
	endsequence
	sequence seq_rx_fall;
		rx_state_reg == uart_fc_pkg::RX_IDLE && rx_prev_reg && !rx_i;
	endsequence

	chk_start_bit_low: assert property (
		seq_tx_go |=> tx_state_reg == uart_fc_pkg::TX_START && !tx_o)
		else $error("start bit not low after start");
	chk_idle_line_high: assert property (
		tx_state_reg == uart_fc_pkg::TX_IDLE |-> tx_o)
		else $error("tx line low while idle");
	chk_stop_line_high: assert property (
		tx_state_reg == uart_fc_pkg::TX_STOP |-> tx_o)
		else $error("stop bit not high");
	chk_parity_value: assert property (
		tx_state_reg == uart_fc_pkg::TX_PAR |-> tx_o == tx_par)
		else $error("wrong parity bit");
	chk_cts_hold: assert property (
		cts_en_i && cts_i != cts_pol_i &&
		tx_state_reg == uart_fc_pkg::TX_IDLE |=>
		tx_state_reg == uart_fc_pkg::TX_IDLE)
		else $error("character started with cts inactive");
	chk_rts_inactive: assert property (
		rts_en_i && rx_count_o >= rts_level_i |=> rts_o != $past(rts_pol_i))
		else $error("rts active at or above level");
	chk_rts_active: assert property (
		rts_en_i && rx_count_o < rts_level_i |=> rts_o == $past(rts_pol_i))
		else $error("rts inactive below level");
	chk_mp_data_drop: assert property (
		rx_done && mp_mode_i && mp_slave_i &&
		!rx_word[uart_fc_pkg::ADDR_FLAG] &&
		!rx_match_reg |-> !rx_push)
		else $error("data stored after mismatched address");
	chk_addr_accept: assert property (
		rx_done && mp_mode_i && mp_slave_i &&
		rx_word[uart_fc_pkg::ADDR_FLAG] &&
		!mp_accept_i |-> !rx_push)
		else $error("address stored while not accepted");
	chk_rx_resync: assert property (
		seq_rx_fall |=> rx_state_reg == uart_fc_pkg::RX_START ##1
		rx_state_reg != uart_fc_pkg::RX_DATA)
		else $error("receiver missed start edge");
	chk_data_len: assert property (
		tx_state_reg == uart_fc_pkg::TX_DATA |-> tx_bit_reg < len)
		else $error("data field longer than set");
	chk_mp_no_parity: assert property (
		mp_mode_i && tx_state_reg == uart_fc_pkg::TX_DATA |=>
		tx_state_reg != uart_fc_pkg::TX_PAR)
		else $error("parity sent in multiprocessor mode");
endmodule

// >>> uart_flow_control_multidrop_test.sv
// self-checking bench of the flow controlled multidrop uart
// assumes the peer model on the serial lines and the cts pin
`timescale 1ns/1ps

`define CHECK(name, exp, got) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) begin \
			$display("[FAIL] %s expected %h got %h", name, exp, got); \
			mismatches++; \
		end \
	end

module uart_flow_control_multidrop_test;
	localparam int DIV = 8;
	localparam int LIMIT = 20000;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [15:0] bit_div_i = 16'h0008;
	logic [1:0] data_len_i = 2'h3;
	logic [1:0] stop_bits_i = 2'h1;
	logic [3:0] rts_level_i = 4'h2;
	logic [8:0] tx_data_i = 9'h000;
	logic parity_en_i = 1'b0, parity_odd_i = 1'b0, mp_mode_i = 1'b0;
	logic mp_slave_i = 1'b0, mp_accept_i = 1'b0, rts_en_i = 1'b0;
	logic rts_pol_i = 1'b0, cts_en_i = 1'b0, cts_pol_i = 1'b0;
	logic tx_valid_i = 1'b0, rx_read_i = 1'b0, err_clr_i = 1'b0;
	logic [7:0] mp_addr_i = 8'h35, mp_mask_i = 8'hf0;
	logic tx_ready_o, rx_data_valid_o, parity_err_o, frame_err_o;
	logic rx_i, tx_o, cts_i, rts_o;
	logic [8:0] rx_data_o;
	logic [3:0] rx_count_o;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;

	always #10 clock_i = ~clock_i;

	uart_flow_control_multidrop dut (
		.clock_i, .reset_n_i, .bit_div_i, .data_len_i, .parity_en_i,
		.parity_odd_i, .stop_bits_i, .mp_mode_i, .mp_slave_i, .mp_addr_i,
		.mp_mask_i, .mp_accept_i, .rts_en_i, .rts_pol_i, .rts_level_i,
		.cts_en_i, .cts_pol_i, .tx_valid_i, .tx_data_i, .tx_ready_o,
		.rx_read_i, .rx_data_o, .rx_data_valid_o, .rx_count_o,
		.parity_err_o, .frame_err_o, .err_clr_i, .rx_i, .tx_o, .cts_i,
		.rts_o
	);

	uart_peer peer (.clock_i, .tx_i(tx_o), .rx_o(rx_i), .cts_o(cts_i));

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic write_word(input logic [8:0] w);
		@(posedge clock_i);
		tx_valid_i <= 1'b1;
		tx_data_i <= w;
		for (int i = 0; i < 2000; i++) begin
			@(negedge clock_i);
			if (tx_ready_o === 1'b1) break;
		end
		@(posedge clock_i);
		tx_valid_i <= 1'b0;
	endtask

	task automatic chk_read(input logic [8:0] exp);
		logic seen;
		seen = 1'b0;
		@(posedge clock_i);
		rx_read_i <= 1'b1;
		@(posedge clock_i);
		rx_read_i <= 1'b0;
		for (int i = 0; i < 3 && !seen; i++) begin
			@(negedge clock_i);
			seen = (rx_data_valid_o === 1'b1);
		end
		`CHECK("rx_data_valid_o", 1'b1, seen)
		`CHECK("rx_data_o", exp, rx_data_o)
	endtask

	task automatic clear_err();
		@(posedge clock_i);
		err_clr_i <= 1'b1;
		@(posedge clock_i);
		err_clr_i <= 1'b0;
		@(negedge clock_i);
	endtask

	// word lengths and parity modes, two frames back to back
	task automatic t_tx();
		logic [9:0] b1, b2, e;
		logic ok1, ok2;
		int s1, s2, n, p;
		for (int k = 0; k < 12; k++) begin
			n = 5 + k / 3;
			p = k % 3;
			@(posedge clock_i);
			data_len_i <= 2'(k / 3);
			parity_en_i <= (p != 0);
			parity_odd_i <= (p == 2);
			stop_bits_i <= 2'(p + 1);
			e = 10'(9'h0b5 ^ 9'(k)) & ((10'h1 << n) - 10'h1);
			if (p != 0) e[n] = (^e) ^ (p == 2);
			fork
				begin
					write_word(9'h0b5 ^ 9'(k));
					write_word(9'h0b5 ^ 9'(k));
				end
				begin
					peer.recv(n + (p != 0), b1, ok1, s1);
					peer.recv(n + (p != 0), b2, ok2, s2);
				end
			join
			`CHECK("tx frame", {e, e}, {b1, b2})
			`CHECK("tx stop", 1'b1, ok1 && ok2)
			`CHECK("tx spacing", (2 + n + p + (p != 0)) * DIV + 1, s2 - s1)
		end
	endtask

	task automatic t_rx();
		logic [8:0] d;
		int n, p;
		for (int k = 0; k < 12; k++) begin
			n = 5 + k / 3;
			p = k % 3;
			@(posedge clock_i);
			data_len_i <= 2'(k / 3);
			parity_en_i <= (p != 0);
			parity_odd_i <= (p == 2);
			d = (9'h0ca ^ 9'(k)) & ((9'h1 << n) - 9'h1);
			peer.send({1'b0, d} | (10'((^d) ^ (p == 2)) << n), n + (p != 0), 1'b1);
			chk_read(d);
		end
		`CHECK("no rx errors", 2'h0, {parity_err_o, frame_err_o})
		peer.send(10'h0f0, 9, 1'b1);
		@(negedge clock_i);
		`CHECK("parity_err_o", 1'b1, parity_err_o)
		chk_read(9'h0f0);
		clear_err();
		`CHECK("errors cleared", 2'h0, {parity_err_o, frame_err_o})
		peer.send(10'h1f0, 9, 1'b0);
		@(negedge clock_i);
		`CHECK("frame_err_o", 2'h1, {parity_err_o, frame_err_o})
		chk_read(9'h0f0);
		clear_err();
		peer.glitch(2);
		peer.send(10'h1a5, 9, 1'b1);
		@(negedge clock_i);
		`CHECK("rx_count_o", 4'h1, rx_count_o)
		chk_read(9'h0a5);
	endtask

	task automatic t_rts();
		@(posedge clock_i);
		{data_len_i, parity_en_i, stop_bits_i} <= {2'h3, 1'b0, 2'h1};
		{rts_en_i, rts_pol_i, rts_level_i} <= {1'b1, 1'b0, 4'h2};
		repeat (2) @(negedge clock_i);
		`CHECK("rts_o empty", 1'b0, rts_o)
		peer.send(10'h011, 8, 1'b1);
		peer.send(10'h022, 8, 1'b1);
		repeat (2) @(negedge clock_i);
		`CHECK("rts_o at level", 1'b1, rts_o)
		peer.send(10'h033, 8, 1'b1);
		chk_read(9'h011);
		repeat (2) @(negedge clock_i);
		`CHECK("rts_o held", 1'b1, rts_o)
		chk_read(9'h022);
		repeat (2) @(negedge clock_i);
		`CHECK("rts_o below", 1'b0, rts_o)
		@(posedge clock_i);
		rts_pol_i <= 1'b1;
		repeat (2) @(negedge clock_i);
		`CHECK("rts_o inverted", 1'b1, rts_o)
		@(posedge clock_i);
		{rts_en_i, rts_pol_i, rts_level_i} <= {1'b0, 1'b0, 4'h1};
		repeat (2) @(negedge clock_i);
		`CHECK("rts_o disabled", 1'b0, rts_o)
		chk_read(9'h033);
	endtask

	task automatic t_cts();
		logic [9:0] b;
		logic ok;
		int s, lows;
		for (int k = 0; k < 3; k++) begin
			@(posedge clock_i);
			cts_en_i <= (k != 2);
			cts_pol_i <= (k == 1);
			peer.set_cts(k != 1);
			lows = 0;
			fork
				begin
					write_word(9'h05a + 9'(k));
					for (int i = 0; i < 4 * DIV; i++) begin
						@(negedge clock_i);
						lows += (tx_o === 1'b0);
					end
					peer.set_cts(k == 1);
				end
				peer.recv(8, b, ok, s);
			join
			`CHECK("tx held", (k != 2), (lows == 0))
			`CHECK("tx after cts", {1'b1, 10'h05a + 10'(k)}, {ok, b})
		end
	endtask

	// tx fifo fills while cts is inactive, then drains in order
	task automatic t_full();
		logic [9:0] b;
		logic ok;
		int s;
		@(posedge clock_i);
		{cts_en_i, cts_pol_i} <= 2'b10;
		peer.set_cts(1'b1);
		for (int i = 0; i < 8; i++) begin
			write_word(9'h0c0 + 9'(i));
		end
		@(negedge clock_i);
		`CHECK("tx_ready_o full", 1'b0, tx_ready_o)
		peer.set_cts(1'b0);
		for (int i = 0; i < 8; i++) begin
			peer.recv(8, b, ok, s);
			`CHECK("tx fifo order", {1'b1, 10'h0c0 + 10'(i)}, {ok, b})
		end
		`CHECK("tx_ready_o drained", 1'b1, tx_ready_o)
	endtask

	task automatic t_mp();
		logic [9:0] b;
		logic ok;
		int s;
		@(posedge clock_i);
		{mp_mode_i, mp_slave_i, mp_accept_i} <= 3'b110;
		{parity_en_i, parity_odd_i} <= 2'b11;
		peer.send(10'h0aa, 9, 1'b1);
		peer.send(10'h13a, 9, 1'b1);
		peer.send(10'h055, 9, 1'b1);
		peer.send(10'h142, 9, 1'b1);
		peer.send(10'h066, 9, 1'b1);
		@(posedge clock_i);
		mp_accept_i <= 1'b1;
		peer.send(10'h13f, 9, 1'b1);
		peer.send(10'h077, 9, 1'b1);
		`CHECK("mp stored", 4'h3, rx_count_o)
		`CHECK("mp parity off", 1'b0, parity_err_o)
		chk_read(9'h055);
		chk_read(9'h13f);
		chk_read(9'h077);
		@(posedge clock_i);
		mp_slave_i <= 1'b0;
		peer.send(10'h0c3, 9, 1'b1);
		chk_read(9'h0c3);
		fork
			write_word(9'h1a5);
			peer.recv(9, b, ok, s);
		join
		`CHECK("mp tx frame", 11'h5a5, {ok, b})
		@(posedge clock_i);
		mp_mode_i <= 1'b0;
	endtask

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			results();
		end
	end

	initial begin
		repeat (4) @(posedge clock_i);
		reset_n_i <= 1'b1;
		@(negedge clock_i);
		`CHECK("idle line", 3'h7, {tx_o, tx_ready_o, rx_count_o == 4'h0})
		t_tx();
		t_rx();
		t_rts();
		t_cts();
		t_full();
		t_mp();
		results();
	end
endmodule

// >>> uart_peer.sv
// peer uart model: drives the serial line and cts, decodes tx frames
// assumes the bench clock and the same clocks per bit as the block
`timescale 1ns/1ps

module uart_peer (
	input wire logic clock_i, // bench clock
	input wire logic tx_i, // line from the block
	output logic rx_o, // line into the block
	output logic cts_o // clear to send into the block
);
	int div = 8;
	int cyc = 0;

	initial begin
		rx_o = 1'b1;
		cts_o = 1'b1;
	end

	always @(posedge clock_i) begin
		cyc <= cyc + 1;
	end

	task automatic send(input logic [9:0] bits, input int n, input logic stp);
		@(posedge clock_i);
		rx_o <= 1'b0;
		repeat (div) @(posedge clock_i);
		for (int i = 0; i < n; i++) begin
			rx_o <= bits[i];
			repeat (div) @(posedge clock_i);
		end
		rx_o <= stp;
		repeat (div) @(posedge clock_i);
		rx_o <= 1'b1;
		repeat (div) @(posedge clock_i);
	endtask

	// short low pulse, no frame behind it
	task automatic glitch(input int c);
		@(posedge clock_i);
		rx_o <= 1'b0;
		repeat (c) @(posedge clock_i);
		rx_o <= 1'b1;
		repeat (div) @(posedge clock_i);
	endtask

	task automatic set_cts(input logic v);
		@(posedge clock_i);
		cts_o <= v;
	endtask

	// samples each bit mid period, t0 is the start cycle
	task automatic recv(input int n, output logic [9:0] bits, output logic ok,
		output int t0);
		int i;
		bits = '0;
		ok = 1'b0;
		t0 = 0;
		for (i = 0; i < 5000 && tx_i !== 1'b0; i++) @(negedge clock_i);
		if (tx_i !== 1'b0) return;
		t0 = cyc;
		repeat (div / 2) @(negedge clock_i);
		ok = (tx_i === 1'b0);
		for (i = 0; i < n; i++) begin
			repeat (div) @(negedge clock_i);
			bits[i] = tx_i;
		end
		repeat (div) @(negedge clock_i);
		ok = ok && (tx_i === 1'b1);
	endtask
endmodule
